// File: hdl/sgc_params.svh
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets, byte addresses within the port window.
// ----------------------------------------------------------------------------
`define SGC_OFS_OUT_SET   12'h000
`define SGC_OFS_OUT_CLR   12'h004
`define SGC_OFS_OUT_VAL   12'h008
`define SGC_OFS_IN_LVL    12'h00c
`define SGC_OFS_DIR       12'h010
`define SGC_OFS_FLAGS     12'h014
`define SGC_OFS_ENABLE    12'h018
`define SGC_OFS_ACTIVE    12'h01c
`define SGC_OFS_FUNC      12'h020

// ----------------------------------------------------------------------------
// Widths and reset values.
// ----------------------------------------------------------------------------
`define SGC_PINS          32
`define SGC_AW            12
`define SGC_RST_WORD      32'h0000_0000

`endif

// File: hdl/sgc_pkg.sv
package sgc_pkg;
    // ------------------------------------------------------------------------
    // Shared types.
    // ------------------------------------------------------------------------
    typedef logic [31:0] sgc_word_t;
    typedef logic [11:0] sgc_addr_t;
endpackage

// File: hdl/sgc_gpio.sv
// Local design decision: register access over APB.
`include "sgc_params.svh"

// Function
// (R01) Each register holds one bit per pin, bit n for pin n from bit 0.
// (R02) Writing the set register forces output bits written as one to one.
// (R03) Writing the clear register forces output bits written as one to zero.
// (R04) Set and clear registers always read back as all zeros.
// (R05) Set and clear act per bit in one step, needing no software locking.
// (R06) Each output value bit gives the driven level of an output pin.
// (R07) The output value register is also directly readable and writable.
// (R08) The input register returns the present level on each pin.
// (R09) Direction bit zero selects input, one selects output and enables driver.
// (R10) A change flag sets when its pin input changes and stays until cleared.
// (R11) Each enable bit lets its pin take part in interrupts, per pin.
// (R12) The active source register is change flags AND enables.
// (R13) Function bit zero keeps port control, one hands pin to alternate function.
// (R14) Writing one clears a change flag; writing zero leaves it.
// (R15) Inputs pass a two-stage synchronizer; interrupt is high while any source set.
module sgc_gpio (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire sgc_pkg::sgc_addr_t    paddr,
    input  wire sgc_pkg::sgc_word_t    pwdata,
    output logic                       pready,
    output sgc_pkg::sgc_word_t         prdata,
    output logic                       pslverr,
    // Device pins.
    input  wire logic [31:0]           pin_in,
    output logic [31:0]                pin_out,
    output logic [31:0]                pin_oe,
    // Alternate peripheral functions.
    input  wire logic [31:0]           alt_out,
    input  wire logic [31:0]           alt_oe,
    output logic [31:0]                alt_in,
    // Interrupt.
    output logic                       irq
);

    // ------------------------------------------------------------------------
    // Register storage and internal state.
    // ------------------------------------------------------------------------
    sgc_pkg::sgc_word_t out_val_r;
    sgc_pkg::sgc_word_t dir_r;
    sgc_pkg::sgc_word_t flags_r;
    sgc_pkg::sgc_word_t enable_r;
    sgc_pkg::sgc_word_t func_r;
    sgc_pkg::sgc_word_t sync1_r;
    sgc_pkg::sgc_word_t sync2_r;
    sgc_pkg::sgc_word_t prev_r;
    sgc_pkg::sgc_word_t rdata_nxt;
    sgc_pkg::sgc_word_t change;
    sgc_pkg::sgc_word_t flags_clr;
    sgc_pkg::sgc_word_t active;
    logic               pready_r;
    logic               mapped;
    logic               wr_acc;
    logic               rd_acc;
    logic               setup_acc;

    // Compares the bus address with a register offset.
    function automatic logic hit(input sgc_pkg::sgc_addr_t a, input sgc_pkg::sgc_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // APB handshake.
    // ------------------------------------------------------------------------

    // Access phase waits one cycle so that read data can be taken from a flop.
    assign setup_acc = psel && penable && !pready_r;
    assign wr_acc    = psel && penable && pready_r && pwrite;
    assign rd_acc    = psel && penable && pready_r && !pwrite;

    // Ready rises one cycle into the access phase and falls after it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_acc;
        end
    end

    assign pready = pready_r;

    // Address decode for the error answer; the read mux decodes paddr on its own.
    always_comb begin
        mapped = hit(paddr, `SGC_OFS_OUT_SET) || hit(paddr, `SGC_OFS_OUT_CLR)
              || hit(paddr, `SGC_OFS_OUT_VAL) || hit(paddr, `SGC_OFS_IN_LVL)
              || hit(paddr, `SGC_OFS_DIR)     || hit(paddr, `SGC_OFS_FLAGS)
              || hit(paddr, `SGC_OFS_ENABLE)  || hit(paddr, `SGC_OFS_ACTIVE)
              || hit(paddr, `SGC_OFS_FUNC);
    end

    // Read multiplexer; set, clear and unmapped offsets return zero.
    always_comb begin
        rdata_nxt = `SGC_RST_WORD;
        case (paddr)
            `SGC_OFS_OUT_SET: rdata_nxt = `SGC_RST_WORD;  // [R04]
            `SGC_OFS_OUT_CLR: rdata_nxt = `SGC_RST_WORD;  // [R04]
            `SGC_OFS_OUT_VAL: rdata_nxt = out_val_r;      // [R07]
            `SGC_OFS_IN_LVL:  rdata_nxt = sync2_r;        // [R08]
            `SGC_OFS_DIR:     rdata_nxt = dir_r;
            `SGC_OFS_FLAGS:   rdata_nxt = flags_r;
            `SGC_OFS_ENABLE:  rdata_nxt = enable_r;
            `SGC_OFS_ACTIVE:  rdata_nxt = active;         // [R12]
            `SGC_OFS_FUNC:    rdata_nxt = func_r;
            default:          rdata_nxt = `SGC_RST_WORD;
        endcase
    end

    // Read data and error are loaded as ready rises and cleared otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= `SGC_RST_WORD;
            pslverr <= 1'b0;
        end else if (setup_acc) begin
            prdata  <= pwrite ? `SGC_RST_WORD : rdata_nxt;
            pslverr <= !mapped;
        end else begin
            prdata  <= `SGC_RST_WORD;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Output value with direct, set and clear access.
    // ------------------------------------------------------------------------

    // Set and clear are single read-free updates, so threads never race.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_val_r <= `SGC_RST_WORD;
        end else if (wr_acc && hit(paddr, `SGC_OFS_OUT_VAL)) begin
            out_val_r <= pwdata;                          // [R07]
        end else if (wr_acc && hit(paddr, `SGC_OFS_OUT_SET)) begin
            out_val_r <= out_val_r | pwdata;              // [R02] [R05]
        end else if (wr_acc && hit(paddr, `SGC_OFS_OUT_CLR)) begin
            out_val_r <= out_val_r & ~pwdata;             // [R03] [R05]
        end
    end

    // ------------------------------------------------------------------------
    // Plain configuration registers.
    // ------------------------------------------------------------------------

    // Direction, interrupt enable and function select.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r    <= `SGC_RST_WORD;
            enable_r <= `SGC_RST_WORD;
            func_r   <= `SGC_RST_WORD;
        end else if (wr_acc) begin
            if (hit(paddr, `SGC_OFS_DIR)) begin
                dir_r <= pwdata;                          // [R09]
            end
            if (hit(paddr, `SGC_OFS_ENABLE)) begin
                enable_r <= pwdata;                       // [R11]
            end
            if (hit(paddr, `SGC_OFS_FUNC)) begin
                func_r <= pwdata;                         // [R13]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input synchronizer and change detection.
    // ------------------------------------------------------------------------

    // Two stages, then a third copy for edge detection on the settled value.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= `SGC_RST_WORD;
            sync2_r <= `SGC_RST_WORD;
            prev_r  <= `SGC_RST_WORD;
        end else begin
            sync1_r <= pin_in;                            // [R15]
            sync2_r <= sync1_r;                           // [R15]
            prev_r  <= sync2_r;
        end
    end

    // Change events and clear mask of a one-to-clear write.
    assign change    = sync2_r ^ prev_r;                  // [R10]
    assign flags_clr = (wr_acc && hit(paddr, `SGC_OFS_FLAGS)) ? pwdata : `SGC_RST_WORD;
    assign active    = flags_r & enable_r;                // [R12]

    // Sticky flags; a change in the clearing cycle still sets its flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= `SGC_RST_WORD;
        end else begin
            flags_r <= (flags_r & ~flags_clr) | change;   // [R10] [R14]
        end
    end

    // Level interrupt, high while any enabled flag is set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |active;                               // [R15]
        end
    end

    // ------------------------------------------------------------------------
    // Per-pin drive and alternate function routing.
    // ------------------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < `SGC_PINS; n++) begin : g_pin
            // Pin n follows bit n of the function, output value and direction registers.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[n] <= 1'b0;
                    pin_oe[n]  <= 1'b0;
                    alt_in[n]  <= 1'b0;
                end else begin
                    pin_out[n] <= func_r[n] ? alt_out[n] : out_val_r[n]; // [R01] [R06] [R13]
                    pin_oe[n]  <= func_r[n] ? alt_oe[n] : dir_r[n];      // [R09] [R13]
                    alt_in[n]  <= func_r[n] ? sync2_r[n] : 1'b0;         // [R13]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_set_bits: assert property ( // [R02]
        wr_acc && hit(paddr, `SGC_OFS_OUT_SET)
        |=> (out_val_r & $past(pwdata)) == $past(pwdata))
        else $error("set write did not raise output bits");

    a_clr_bits: assert property ( // [R03]
        wr_acc && hit(paddr, `SGC_OFS_OUT_CLR)
        |=> (out_val_r & $past(pwdata)) == 32'h0000_0000)
        else $error("clear write did not drop output bits");

    a_set_clr_zero: assert property ( // [R04]
        rd_acc && (hit(paddr, `SGC_OFS_OUT_SET) || hit(paddr, `SGC_OFS_OUT_CLR))
        |-> prdata == 32'h0000_0000)
        else $error("set or clear register read nonzero");

    a_other_bits_kept: assert property ( // [R05]
        wr_acc && (hit(paddr, `SGC_OFS_OUT_SET) || hit(paddr, `SGC_OFS_OUT_CLR))
        |=> (out_val_r & ~$past(pwdata)) == ($past(out_val_r) & ~$past(pwdata)))
        else $error("set or clear touched unwritten bits");

    a_out_drive: assert property ( // [R06]
        ##1 (pin_out & ~$past(func_r)) == ($past(out_val_r) & ~$past(func_r)))
        else $error("port pin level differs from output value");

    a_out_write: assert property ( // [R07]
        wr_acc && hit(paddr, `SGC_OFS_OUT_VAL)
        |=> out_val_r == $past(pwdata))
        else $error("direct output value write not taken");

    a_out_read: assert property ( // [R07]
        rd_acc && hit(paddr, `SGC_OFS_OUT_VAL)
        |-> prdata == $past(out_val_r))
        else $error("output value read back wrong");

    a_in_level: assert property ( // [R08]
        ##2 sync2_r == $past(pin_in, 2))
        else $error("input level not two cycles behind pin");

    a_in_read: assert property ( // [R08]
        rd_acc && hit(paddr, `SGC_OFS_IN_LVL)
        |-> prdata == $past(sync2_r))
        else $error("input level read differs from pins");

    a_dir_drive: assert property ( // [R09]
        ##1 (pin_oe & ~$past(func_r)) == ($past(dir_r) & ~$past(func_r)))
        else $error("driver enable differs from direction");

    a_dir_write: assert property ( // [R09]
        wr_acc && hit(paddr, `SGC_OFS_DIR)
        |=> dir_r == $past(pwdata))
        else $error("direction write not taken");

    a_change_sets: assert property ( // [R10]
        change != 32'h0000_0000
        |=> (flags_r & $past(change)) == $past(change))
        else $error("input change did not set its flag");

    a_flag_sticky: assert property ( // [R10]
        flags_clr == 32'h0000_0000 |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("change flag dropped without a clear");

    a_enable_write: assert property ( // [R11]
        wr_acc && hit(paddr, `SGC_OFS_ENABLE)
        |=> enable_r == $past(pwdata))
        else $error("interrupt enable write not taken");

    a_w1c_clear: assert property ( // [R14]
        wr_acc && hit(paddr, `SGC_OFS_FLAGS)
        |=> flags_r == (($past(flags_r) & ~$past(pwdata)) | $past(change)))
        else $error("one-to-clear write misbehaved");

    a_zero_kept: assert property ( // [R14]
        wr_acc && hit(paddr, `SGC_OFS_FLAGS)
        |=> (flags_r & $past(flags_r) & ~$past(pwdata)) == ($past(flags_r) & ~$past(pwdata)))
        else $error("flag written with zero was cleared");

    a_active_read: assert property ( // [R12]
        rd_acc && hit(paddr, `SGC_OFS_ACTIVE)
        |-> prdata == $past(flags_r & enable_r))
        else $error("active source read is not flags and enables");

    a_irq_level: assert property ( // [R11] [R15]
        ##1 irq == $past(|(flags_r & enable_r)))
        else $error("interrupt not tied to enabled flags");

    a_alt_route: assert property ( // [R13]
        ##1 (pin_out & $past(func_r)) == ($past(alt_out) & $past(func_r)))
        else $error("alternate pin not driven by its function");

    a_alt_enable: assert property ( // [R13]
        ##1 (pin_oe & $past(func_r)) == ($past(alt_oe) & $past(func_r)))
        else $error("alternate pin enable not from its function");

    a_alt_input: assert property ( // [R13]
        ##1 alt_in == ($past(sync2_r) & $past(func_r)))
        else $error("alternate input not gated by function select");

    a_func_write: assert property ( // [R13]
        wr_acc && hit(paddr, `SGC_OFS_FUNC)
        |=> func_r == $past(pwdata))
        else $error("function select write not taken");

endmodule

// File: verif/sgc_pin_model.sv
// ----------------------------------------------------------------------------
// Pin wires outside the port.
// ----------------------------------------------------------------------------
module sgc_pin_model (
    // Port side of each pin.
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output logic      [31:0] pin_in,
    // Level that outside parts put on pins the port leaves free.
    input  wire logic [31:0] ext_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // A pin the port drives shows its level, any other the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// File: verif/tb_top.sv
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Signals and reference model state.
    // ------------------------------------------------------------------------
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    sgc_pkg::sgc_addr_t paddr = 12'h000;
    sgc_pkg::sgc_word_t pwdata = 32'h0000_0000;
    sgc_pkg::sgc_word_t prdata, rd;
    logic               pready, pslverr, irq, er;
    logic [31:0]        pin_in, pin_out, pin_oe, alt_in;
    logic [31:0]        alt_out = 32'h0000_0000;
    logic [31:0]        alt_oe = 32'h0000_0000;
    logic [31:0]        ext_lvl = 32'h0000_0000;
    logic [31:0]        m_out, m_dir, m_flg, m_en, m_fn, lvl_old, d, eo, eoe, lvl;
    int                 n_fail, samples_checked, cyc;
    int                 adr[$] = '{0, 4, 8, 12, 16, 20, 24, 28, 32};

    always #25 clk = ~clk;

    sgc_gpio dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .irq(irq));
    sgc_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_lvl(ext_lvl));

    // ------------------------------------------------------------------------
    // Bus, settling and closing tasks.
    // ------------------------------------------------------------------------
    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input int a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(a);
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // A slave that never answers is ended by the cycle ceiling.
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input int a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    // Lets the pins and flags settle, updates the model and checks the pins.
    task automatic settle();
        repeat (6) @(posedge clk);
        eo = (m_fn & alt_out) | (~m_fn & m_out);
        eoe = (m_fn & alt_oe) | (~m_fn & m_dir);
        lvl = (eoe & eo) | (~eoe & ext_lvl);
        m_flg = m_flg | (lvl ^ lvl_old);
        lvl_old = lvl;
        `CHK("pin_out", eo, pin_out)
        `CHK("pin_oe", eoe, pin_oe)
        `CHK("alt_in", m_fn & lvl, alt_in)
        `CHK("irq", |(m_flg & m_en), irq)
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    initial begin
        {m_out, m_dir, m_flg, m_en, m_fn, lvl_old} = '0;
        void'($urandom(16225));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Every register starts at zero.
        foreach (adr[i]) rdchk("reset", adr[i], 32'h0000_0000);
        m_dir = 32'hffff_ffff;
        apb(1'b1, 16, m_dir);
        settle();
        // Direct writes, sets and clears of the output value.
        for (int i = 0; i < 9; i++) begin
            d = $urandom();
            apb(1'b1, (i % 3) * 4 + (i % 3 == 0 ? 8 : -4), d);
            m_out = (i % 3 == 0) ? d : (i % 3 == 1) ? (m_out | d) : (m_out & ~d);
            settle();
            rdchk("out", 8, m_out);
            rdchk("set_clr", 4 * (i % 2), 32'h0000_0000);
        end
        // Mixed directions with outside levels, then change flags.
        for (int i = 0; i < 5; i++) begin
            m_dir = $urandom();
            apb(1'b1, 16, m_dir);
            settle(); // The direction change alone may toggle pins.
            m_en = (i == 0) ? 32'h0000_0000 : $urandom();
            apb(1'b1, 24, m_en);
            @(posedge clk);
            ext_lvl <= $urandom();
            settle();
            rdchk("in", 12, lvl);
            rdchk("dir", 16, m_dir);
            rdchk("flags", 20, m_flg);
            rdchk("enable", 24, m_en);
            rdchk("active", 28, m_flg & m_en);
            d = (i == 1) ? 32'h0000_0000 : $urandom();
            apb(1'b1, 20, d);
            m_flg = m_flg & ~d;
            settle();
            rdchk("flags_w1c", 20, m_flg);
        end
        // Read-only registers ignore writes.
        apb(1'b1, 12, 32'hffff_ffff);
        apb(1'b1, 28, 32'hffff_ffff);
        rdchk("in_ro", 12, lvl);
        rdchk("active_ro", 28, m_flg & m_en);
        // Pins handed to the alternate functions.
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            alt_out <= $urandom();
            alt_oe <= $urandom();
            settle(); // New peripheral levels show before the select moves.
            m_fn = $urandom();
            apb(1'b1, 32, m_fn);
            settle();
            rdchk("func", 32, m_fn);
        end
        // Unmapped address.
        apb(1'b1, 36, 32'hffff_ffff);
        `CHK("slverr_wr", 1'b1, er)
        rdchk("unmapped", 36, 32'h0000_0000);
        `CHK("slverr_rd", 1'b1, er)
        stop_test();
    end
endmodule
